// ==== design/acs_converter.sv ====
// Converter end: power-on hold, calibration sequencing, status and data path.
// Assumes the host supplies a steady sample enable and keeps off the port during POR.
`timescale 1ns/100ps
module acs_converter #(
  parameter longint unsigned CAL_SAMPLES = acs_pkg::CAL_NOM_SAMPLES,
  parameter int unsigned     LATENCY     = acs_pkg::LATENCY_CYCLES
) (
  // System
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // Link
  acs_link_if.dev                 link,
  // Board side
  input  wire logic               supply_good,
  input  wire acs_pkg::acs_strap_t clock_divide_select,
  input  wire logic               div_override_en,
  input  wire acs_pkg::acs_div_t  div_override,
  input  wire logic [15:0]        core_a_sample,
  input  wire logic [15:0]        core_b_sample,
  output logic                    cal_busy
);

  typedef enum logic [1:0] {ACS_POR, ACS_CAL, ACS_RUN} acs_state_t;

  acs_state_t       state_q;
  logic             line_q;
  logic             done_q;
  logic [39:0]      cal_cnt_q;
  logic [15:0]      pipe_q [LATENCY];
  acs_pkg::acs_div_t div_q;
  logic [1:0]       div_cnt_q;
  logic             out_clk_q;
  logic             rise;

  // ********************************************************************
  // Reset line handling
  // ********************************************************************
  assign link.reset_line_dev_o  = 1'b0;
  assign link.reset_line_dev_oe = (state_q == ACS_POR);
  assign rise = link.reset_line & ~line_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_q <= 1'b0;
    end else begin
      line_q <= link.reset_line;
    end
  end

  // ********************************************************************
  // Calibration sequencer
  // ********************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ACS_POR;
      cal_cnt_q <= 40'h0;
      done_q    <= 1'b0;
    end else begin
      unique case (state_q)
        ACS_POR: begin
          if (supply_good) begin
            state_q <= ACS_RUN;
          end
        end
        ACS_CAL: begin
          if (!link.reset_line) begin
            cal_cnt_q <= 40'h0;
          end else if (link.sample_clk_en) begin
            if (cal_cnt_q >= CAL_SAMPLES[39:0] - 40'h1) begin
              state_q <= ACS_RUN;
              done_q  <= 1'b1;
            end else begin
              cal_cnt_q <= cal_cnt_q + 40'h1;
            end
          end
        end
        ACS_RUN: ;
      endcase
      if (state_q != ACS_POR && rise) begin
        state_q   <= ACS_CAL;
        cal_cnt_q <= 40'h0;
        done_q    <= 1'b0;
      end
    end
  end
  assign cal_busy = ~done_q;

  // ********************************************************************
  // Status register read
  // ********************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link.reg_rdata  <= 8'h00;
      link.reg_rvalid <= 1'b0;
    end else begin
      link.reg_rvalid <= link.reg_rd;
      if (link.reg_rd) begin
        link.reg_rdata <= (link.reg_addr == acs_pkg::REG_CAL_STATUS) ?
                          {7'h00, done_q} : 8'h00;
      end
    end
  end

  // ********************************************************************
  // Data path: sum of cores, fixed latency
  // ********************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LATENCY; i++) pipe_q[i] <= 16'h0000;
    end else if (link.sample_clk_en) begin
      pipe_q[0] <= core_a_sample + core_b_sample;
      for (int i = 1; i < LATENCY; i++) pipe_q[i] <= pipe_q[i-1];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link.sample_data  <= acs_pkg::CAL_PATTERN;
      link.sample_valid <= 1'b0;
    end else begin
      link.sample_valid <= link.sample_clk_en;
      if (link.sample_clk_en) begin
        link.sample_data <= done_q ? pipe_q[LATENCY-1] : acs_pkg::CAL_PATTERN;
      end
    end
  end

  // ********************************************************************
  // Divide ratio and output clock
  // ********************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= acs_pkg::ACS_DIV1;
    end else if (div_override_en) begin
      div_q <= div_override;
    end else begin
      unique case (clock_divide_select)
        acs_pkg::ACS_STRAP_LOW:  div_q <= acs_pkg::ACS_DIV2;
        acs_pkg::ACS_STRAP_HIGH: div_q <= acs_pkg::ACS_DIV4;
        default:                 div_q <= acs_pkg::ACS_DIV1;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= 2'h0;
      out_clk_q <= 1'b0;
    end else if (div_q != acs_pkg::ACS_DIV1 && !link.reset_line) begin
      div_cnt_q <= 2'h0;
      out_clk_q <= 1'b0;
    end else if (link.sample_clk_en) begin
      div_cnt_q <= div_cnt_q + 2'h1;
      unique case (div_q)
        acs_pkg::ACS_DIV2: out_clk_q <= ~div_cnt_q[0];
        acs_pkg::ACS_DIV4: out_clk_q <= ~div_cnt_q[1];
        default:           out_clk_q <= ~out_clk_q;
      endcase
    end
  end
  assign link.out_clk = out_clk_q;

endmodule

// ==== design/acs_host.sv ====
// Host end: Wishbone slave controlling recalibration and watching status.
// Assumes a classic Wishbone master on clk_sys.
`timescale 1ns/100ps
module acs_host #(
  parameter int unsigned SAMPLE_DIV = 2,
  parameter longint unsigned TIMEOUT = acs_pkg::CAL_MAX_CLKS
) (
  // System
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Wishbone
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq,
  // Link
  acs_link_if.host         link
);

  typedef enum logic [1:0] {HS_IDLE, HS_RESET, HS_WAIT} hs_state_t;

  hs_state_t   state_q;
  logic [7:0]  div_q;
  logic        en_q;
  logic [39:0] wait_q;
  logic        poll_q;
  logic        done_q;
  logic [1:0]  irq_st_q;
  logic [1:0]  irq_en_q;
  logic [15:0] data_q;
  logic        acc;
  logic        wr;
  logic [1:0]  ev;

  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr  = acc & wb_we_i & wb_sel_i[0];

  // ********************************************************************
  // Sample enable and link drive
  // ********************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 8'h00;
      en_q  <= 1'b0;
    end else begin
      en_q  <= (div_q == 8'(SAMPLE_DIV - 1));
      div_q <= (div_q == 8'(SAMPLE_DIV - 1)) ? 8'h00 : div_q + 8'h01;
    end
  end
  assign link.sample_clk_en      = en_q;
  assign link.reset_line_host_o  = 1'b0;
  assign link.reset_line_host_oe = (state_q == HS_RESET);
  assign link.reg_addr           = acs_pkg::REG_CAL_STATUS;
  assign link.reg_rd             = poll_q;

  // ********************************************************************
  // Recalibration sequence
  // ********************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= HS_IDLE;
      wait_q  <= 40'h0;
      poll_q  <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      poll_q <= 1'b0;
      unique case (state_q)
        HS_IDLE: begin
          if (wr && wb_adr_i == {2'h0, acs_pkg::HOST_CTRL} &&
              wb_dat_i[acs_pkg::CTRL_RECAL_BIT]) begin
            state_q <= HS_RESET;
            done_q  <= 1'b0;
          end
        end
        HS_RESET: begin
          if (en_q) begin
            state_q <= HS_WAIT;
            wait_q  <= 40'h0;
          end
        end
        HS_WAIT: begin
          wait_q <= wait_q + 40'h1;
          // Status polled on the device port only after the timeout window
          if (wait_q == TIMEOUT[39:0]) begin
            poll_q <= 1'b1;
          end
          if (link.reg_rvalid) begin
            done_q  <= link.reg_rdata[acs_pkg::CAL_DONE_BIT];
            state_q <= HS_IDLE;
          end
        end
        default: state_q <= HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= 16'h0000;
    end else if (link.sample_valid) begin
      data_q <= link.sample_data;
    end
  end

  // ********************************************************************
  // Interrupts: done and timeout
  // ********************************************************************
  assign ev[acs_pkg::IRQ_DONE_BIT] = (state_q == HS_WAIT) & link.reg_rvalid &
                                     link.reg_rdata[acs_pkg::CAL_DONE_BIT];
  assign ev[acs_pkg::IRQ_TMO_BIT]  = (state_q == HS_WAIT) & link.reg_rvalid &
                                     ~link.reg_rdata[acs_pkg::CAL_DONE_BIT];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_q <= 2'h0;
      irq_en_q <= 2'h0;
    end else begin
      if (wr && wb_adr_i == acs_pkg::HOST_IRQ_EN_ADDR) begin
        irq_en_q <= wb_dat_i[1:0];
      end
      // Set wins over clear
      if (wr && wb_adr_i == {2'h0, acs_pkg::HOST_IRQ_CLR}) begin
        irq_st_q <= (irq_st_q & ~wb_dat_i[1:0]) | ev;
      end else begin
        irq_st_q <= irq_st_q | ev;
      end
    end
  end
  assign irq = |(irq_st_q & irq_en_q);

  // ********************************************************************
  // Wishbone slave
  // ********************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i) begin
        unique case (wb_adr_i)
          {2'h0, acs_pkg::HOST_STATUS}: wb_dat_o <= {30'h0, state_q != HS_IDLE, done_q};
          {2'h0, acs_pkg::HOST_IRQ_ST}: wb_dat_o <= {30'h0, irq_st_q};
          acs_pkg::HOST_IRQ_EN_ADDR:     wb_dat_o <= {30'h0, irq_en_q};
          acs_pkg::HOST_DATA:            wb_dat_o <= {16'h0, data_q};
          default:                       wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

endmodule

// ==== design/acs_link_if.sv ====
// Interface joining the converter end and the host end.
// Assumes both ends on clk_sys; reset line is open drain with pull-up.
`timescale 1ns/100ps
interface acs_link_if;
  logic        reset_line_host_o;
  logic        reset_line_host_oe;
  logic        reset_line_dev_o;
  logic        reset_line_dev_oe;
  logic        sample_clk_en;
  logic [7:0]  reg_addr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic [15:0] sample_data;
  logic        sample_valid;
  logic        out_clk;
  // Open drain wire with pull-up
  wire reset_line = ~((reset_line_host_oe & ~reset_line_host_o) |
                      (reset_line_dev_oe & ~reset_line_dev_o));

  modport dev (
    input  reset_line, sample_clk_en, reg_addr, reg_rd,
    output reset_line_dev_o, reset_line_dev_oe, reg_rdata, reg_rvalid,
    output sample_data, sample_valid, out_clk
  );
  modport host (
    input  reset_line, reg_rdata, reg_rvalid, sample_data, sample_valid, out_clk,
    output reset_line_host_o, reset_line_host_oe, sample_clk_en, reg_addr, reg_rd
  );
endinterface

// ==== design/acs_pkg.sv ====
// Package for the converter calibration and reset sequencer, both ends.
// Assumes a single 100 MHz system clock; the sample clock is an enable pulse.
package acs_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned SAMPLE_HZ       = 250_000_000;
  localparam int unsigned LATENCY_CYCLES  = 10;
  localparam int unsigned CAL_NOM_MS      = 200;
  localparam int unsigned CAL_MAX_MS      = 550;
  // Calibration length in sample-enable cycles (nominal)
  localparam longint unsigned CAL_NOM_SAMPLES = longint'(SAMPLE_HZ) / 1000 * CAL_NOM_MS;
  localparam longint unsigned CAL_MAX_CLKS    = longint'(CLK_HZ) / 1000 * CAL_MAX_MS;

  // ********************************************************************
  // Device register map and data
  // ********************************************************************
  localparam logic [7:0]  REG_CAL_STATUS = 8'hb6;
  localparam int unsigned CAL_DONE_BIT   = 0;
  localparam logic [15:0] CAL_PATTERN    = 16'hcccc;

  // ********************************************************************
  // Divide ratio strap
  // ********************************************************************
  typedef enum logic [1:0] {ACS_STRAP_LOW, ACS_STRAP_FLOAT, ACS_STRAP_HIGH} acs_strap_t;
  typedef enum logic [1:0] {ACS_DIV1, ACS_DIV2, ACS_DIV4} acs_div_t;

  // ********************************************************************
  // Host Wishbone register map
  // ********************************************************************
  localparam logic [3:0] HOST_CTRL    = 4'h0;
  localparam logic [3:0] HOST_STATUS  = 4'h4;
  localparam logic [3:0] HOST_IRQ_ST  = 4'h8;
  localparam logic [3:0] HOST_IRQ_CLR = 4'hc;
  localparam logic [3:0] HOST_IRQ_EN  = 4'h0 + 4'h0;
  localparam logic [5:0] HOST_IRQ_EN_ADDR = 6'h10;
  localparam logic [5:0] HOST_DATA       = 6'h14;
  localparam int unsigned CTRL_RECAL_BIT = 0;
  localparam int unsigned IRQ_DONE_BIT   = 0;
  localparam int unsigned IRQ_TMO_BIT    = 1;

endpackage

// ==== verif/acs_link_checker.sv ====
// Properties on the wires between the converter end and the host end.
// Assumes an instance beside the link interface, fed its signals by name.
`timescale 1ns/100ps
module acs_link_checker #(
  parameter int CAL_SAMPLES = 50,
  parameter int SAMPLE_DIV  = 2
) (
  // System
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Link
  input wire logic        reset_line,
  input wire logic        reset_line_host_oe,
  input wire logic        sample_clk_en,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic [15:0] sample_data,
  input wire logic        sample_valid
);
  localparam int EN_WIN = 2 * SAMPLE_DIV;
  localparam int EN_GAP = SAMPLE_DIV - 1;
  int   cal_cnt_q;
  logic line_q;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // ****
  // Enables seen since the reset line rose
  // ****
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_q <= 1'b0;
    end else begin
      line_q <= reset_line;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cal_cnt_q <= CAL_SAMPLES;
    end else if (reset_line && !line_q) begin
      cal_cnt_q <= 0;
    end else if (sample_clk_en && cal_cnt_q < CAL_SAMPLES) begin
      cal_cnt_q <= cal_cnt_q + 1;
    end
  end
  // ****
  // Properties
  // ****
  sequence s_host_pull;
    $rose(reset_line_host_oe);
  endsequence
  sequence s_en_soon;
    ##[0:EN_WIN] sample_clk_en;
  endsequence
  a_hold_low: assert property (s_host_pull |-> !reset_line until sample_clk_en)
    else $error("reset line released before a sample enable");
  a_pull_bounded: assert property (s_host_pull |-> s_en_soon)
    else $error("no sample enable while the reset line is pulled");
  a_cal_pattern: assert property (
    sample_valid && cal_cnt_q >= 2 && cal_cnt_q + 2 < CAL_SAMPLES
    |-> sample_data == acs_pkg::CAL_PATTERN)
    else $error("data word not the calibration pattern");
  a_valid_follows: assert property (sample_clk_en |=> sample_valid)
    else $error("no data strobe after a sample enable");
  a_en_period: assert property (sample_clk_en |=> !sample_clk_en ##EN_GAP sample_clk_en)
    else $error("sample enable spacing broken");
  a_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("register read not answered");
  a_rd_status: assert property (reg_rd |-> reg_addr == acs_pkg::REG_CAL_STATUS)
    else $error("poll at wrong register offset");
  a_done_poll: assert property (reg_rvalid |-> reg_rdata[acs_pkg::CAL_DONE_BIT])
    else $error("done bit low when polled after the wait");
  a_no_rd_cal: assert property (reg_rd |-> cal_cnt_q == CAL_SAMPLES)
    else $error("register access during calibration");
endmodule

// ==== verif/acs_tb_top.sv ====
// Testbench: both ends joined by the link, driven over Wishbone and board pins.
// Assumes the design files and the link checker are compiled first.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module acs_tb_top;
  localparam int CAL_N = 50;
  localparam int DIV   = 2;
  logic                clk_sys = 1'b0;
  logic                rst_n = 1'b0;
  logic                wb_cyc = 1'b0;
  logic                wb_stb = 1'b0;
  logic                wb_we = 1'b0;
  logic [5:0]          wb_adr = 6'h00;
  logic [31:0]         wb_dat = 32'h0;
  logic [3:0]          wb_sel = 4'h0;
  logic [31:0]         wb_rdat;
  logic                wb_ack;
  logic                irq;
  logic                cal_busy;
  logic                supply_good = 1'b0;
  acs_pkg::acs_strap_t strap = acs_pkg::ACS_STRAP_FLOAT;
  logic                ovr_en = 1'b0;
  acs_pkg::acs_div_t   ovr = acs_pkg::ACS_DIV1;
  logic [15:0]         core_a = 16'h0000;
  logic [15:0]         core_b = 16'h1000;
  logic [15:0]         hist[$];
  bit                  chk_data = 1'b0;
  int                  n_fail = 0;
  int                  samples_checked = 0;
  int                  cycles = 0;
  acs_link_if link ();
  acs_converter #(.CAL_SAMPLES(CAL_N), .LATENCY(10)) acs_converter_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .link(link), .supply_good(supply_good),
    .clock_divide_select(strap), .div_override_en(ovr_en), .div_override(ovr),
    .core_a_sample(core_a), .core_b_sample(core_b), .cal_busy(cal_busy));
  acs_host #(.SAMPLE_DIV(DIV), .TIMEOUT(200)) acs_host_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .irq(irq), .link(link));
  acs_link_checker #(.CAL_SAMPLES(CAL_N), .SAMPLE_DIV(DIV)) acs_link_checker_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .reset_line(link.reset_line),
    .reset_line_host_oe(link.reset_line_host_oe), .sample_clk_en(link.sample_clk_en),
    .reg_addr(link.reg_addr), .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata),
    .reg_rvalid(link.reg_rvalid), .sample_data(link.sample_data),
    .sample_valid(link.sample_valid));
  always #5 clk_sys = ~clk_sys;
  // Cores move every clock, history kept per sample enable
  always @(posedge clk_sys) begin
    core_a <= core_a + 16'h0101;
    core_b <= core_b + 16'h0007;
    cycles++;
    if (chk_data && link.sample_valid === 1'b1 && hist.size() > 11)
      `CHK(link.sample_data, hist[hist.size() - 11])
    if (link.sample_clk_en === 1'b1) hist.push_back(core_a + core_b);
    if (cycles == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wb_xfer(input logic we, input logic [5:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= 4'h1;
    @(posedge clk_sys);
    // Only the bench cycle ceiling ends a wait for the answer
    while (wb_ack !== 1'b1) begin
      @(posedge clk_sys);
    end
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb_xfer(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  task automatic count_oclk(input int n, output int tg);
    logic last;
    tg = 0;
    last = link.out_clk;
    repeat (n) begin
      @(posedge clk_sys);
      if (link.out_clk !== last) tg++;
      last = link.out_clk;
    end
  endtask
  // Power-on hold with a given divide setting, then calibration
  task automatic por_run(input acs_pkg::acs_strap_t s, input logic oe,
                         input acs_pkg::acs_div_t d, input logic held);
    int tg;
    int n;
    strap <= s;
    ovr_en <= oe;
    ovr <= d;
    supply_good <= 1'b0;
    chk_data = 1'b0;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    count_oclk(20, tg);
    `CHK(link.reset_line, 1'b0)
    `CHK(tg == 0, held)
    supply_good <= 1'b1;
    count_oclk(8, tg);
    `CHK(tg != 0, 1'b1)
    n = 0;
    while (cal_busy !== 1'b0 && n < 1000) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK(n >= 2 * CAL_N - 16 && n <= 2 * CAL_N, 1'b1)
    repeat (30) @(posedge clk_sys);
    chk_data = 1'b1;
    $display("test power-on strap=%0d override=%0b done", s, oe);
  endtask
  initial begin
    int n;
    por_run(acs_pkg::ACS_STRAP_LOW, 1'b0, acs_pkg::ACS_DIV1, 1'b1);
    por_run(acs_pkg::ACS_STRAP_HIGH, 1'b0, acs_pkg::ACS_DIV1, 1'b1);
    por_run(acs_pkg::ACS_STRAP_LOW, 1'b1, acs_pkg::ACS_DIV1, 1'b0);
    por_run(acs_pkg::ACS_STRAP_FLOAT, 1'b0, acs_pkg::ACS_DIV1, 1'b0);
    repeat (40) @(posedge clk_sys);
    rd(6'h3c, 32'h0);
    wr(acs_pkg::HOST_IRQ_EN_ADDR, 32'h1);
    rd(acs_pkg::HOST_IRQ_EN_ADDR, 32'h1);
    chk_data = 1'b0;
    wr(6'(acs_pkg::HOST_CTRL), 32'h1);
    repeat (10) @(posedge clk_sys);
    `CHK(cal_busy, 1'b1)
    `CHK(link.sample_data, acs_pkg::CAL_PATTERN)
    n = 0;
    while (irq !== 1'b1 && n < 1000) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK(irq, 1'b1)
    `CHK(cal_busy, 1'b0)
    rd(6'(acs_pkg::HOST_IRQ_ST), 32'h1);
    rd(6'(acs_pkg::HOST_STATUS), 32'h1);
    wr(6'(acs_pkg::HOST_IRQ_CLR), 32'h1);
    `CHK(irq, 1'b0)
    rd(6'(acs_pkg::HOST_IRQ_ST), 32'h0);
    $display("test recalibration interrupt done");
    wr(acs_pkg::HOST_IRQ_EN_ADDR, 32'h0);
    wr(6'(acs_pkg::HOST_CTRL), 32'h1);
    repeat (300) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    rd(6'(acs_pkg::HOST_IRQ_ST), 32'h1);
    $display("test masked interrupt done");
    wrap_up();
  end
endmodule
